// >>> hw/uartm_pkg.sv
// Constants, register map and field layout of the modem, flow and RS-485 control block.
// Assumes a 32-bit APB register bus with one aligned word for each 8-bit register.
package uartm_pkg;

    // Register byte addresses.
    localparam logic [7:0] OFS_MODEM_STATUS = 8'h00;
    localparam logic [7:0] OFS_SCRATCH_PAD = 8'h04;
    localparam logic [7:0] OFS_FEATURE_CONTROL = 8'h08;
    localparam logic [7:0] OFS_ENHANCED_FEATURE = 8'h0C;
    localparam logic [7:0] OFS_MODEM_CONTROL = 8'h10;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE = 8'h14;

    // Reset values.
    localparam logic [7:0] SCRATCH_RST = 8'hFF;
    localparam logic [7:0] FEATURE_RST = 8'h00;
    localparam logic [7:0] ENHANCED_RST = 8'h00;
    localparam logic [7:0] MODEM_CTL_RST = 8'h00;
    localparam logic [7:0] INT_EN_RST = 8'h00;
    localparam logic [7:0] TURN_HALT_RST = 8'h00;

    // Bits that only change while the enhanced-function enable is set.
    localparam logic [7:0] TURN_ENH_MASK = 8'hFC;
    localparam logic [7:0] MODEM_CTL_ENH_MASK = 8'hEC;
    localparam logic [7:0] INT_EN_ENH_MASK = 8'hE0;

    // Field positions.
    localparam int IEN_MODEM_BIT = 3;
    localparam int ENH_AUTO_CTS_BIT = 7;
    localparam int ENH_AUTO_RTS_BIT = 6;
    localparam int ENH_ENABLE_BIT = 4;
    localparam int FC_RS485_BIT = 5;
    localparam int FC_IRPOL_BIT = 4;
    localparam int TH_TX_OFF_BIT = 3;
    localparam int TH_RX_OFF_BIT = 2;
    localparam int MC_PAIR_BIT = 2;
    localparam int MC_RTS_BIT = 1;
    localparam int MC_DTR_BIT = 0;
    localparam logic [1:0] TABLE_D = 2'h3;
    localparam int RX_LVL_W = 7;

    typedef enum logic [1:0] {DIR_IDLE, DIR_SEND, DIR_WAIT} uartm_dir_t;

    // Hysteresis in characters for each table-D code.
    function automatic logic [RX_LVL_W-1:0] uartm_hyst(input logic [3:0] code);
        logic [RX_LVL_W-1:0] h;
        h = 7'h00;
        case (code)
            4'h0: h = 7'h00;
            4'h1: h = 7'h04;
            4'h2: h = 7'h06;
            4'h3: h = 7'h08;
            4'h4: h = 7'h08;
            4'h5: h = 7'h10;
            4'h6: h = 7'h18;
            4'h7: h = 7'h20;
            4'h8: h = 7'h28;
            4'h9: h = 7'h2C;
            4'hA: h = 7'h30;
            4'hB: h = 7'h34;
            4'hC: h = 7'h0C;
            4'hD: h = 7'h14;
            4'hE: h = 7'h1C;
            default: h = 7'h24;
        endcase
        return h;
    endfunction

endpackage

// >>> hw/uartm_rs485_if.sv
// Link between the control core and the RS-485 turnaround timer.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface uartm_rs485_if;
    logic enable;
    logic bit_tick;
    logic tx_idle;
    logic [3:0] delay;
    logic drive;
    modport ctl (output enable, output bit_tick, output tx_idle, output delay, input drive);
    modport dir (input enable, input bit_tick, input tx_idle, input delay, output drive);
endinterface
`default_nettype wire

// >>> hw/uartm_delta.sv
// Two-stage synchroniser and delta flag for one modem input pin.
// Assumes the pin is asynchronous to clk_sys and idles high.
`timescale 1ns/1ns
`default_nettype none
module uartm_delta #(
    parameter bit RISE_ONLY = 1'b0
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic pin_n,
    input wire logic clr,
    output logic level_ff,
    output logic flag_ff
);
    logic meta_ff;
    logic prev_ff;
    logic change;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= 1'b1;
            level_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            meta_ff <= pin_n;
            level_ff <= meta_ff;
            prev_ff <= level_ff;
        end
    end

    assign change = RISE_ONLY ? (level_ff & ~prev_ff) : (level_ff ^ prev_ff);

    // A change seen in the cycle of the clearing read survives the read.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= change | (flag_ff & ~clr);
        end
    end
endmodule
`default_nettype wire

// >>> hw/uartm_turnaround.sv
// RS-485 direction timer: holds the direction output through transmission and N bit times after.
// Assumes bit_tick pulses once per bit time and tx_idle means queue and shifter are empty.
`timescale 1ns/1ns
`default_nettype none
module uartm_turnaround
    import uartm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    uartm_rs485_if.dir bus
);
    uartm_dir_t state_ff;
    logic [3:0] cnt_ff;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff <= DIR_IDLE;
            cnt_ff <= 4'h0;
            bus.drive <= 1'b0;
        end else begin
            case (state_ff)
                DIR_IDLE: begin
                    if (bus.enable && !bus.tx_idle) begin
                        state_ff <= DIR_SEND;
                        bus.drive <= 1'b1;
                    end
                end
                DIR_SEND: begin
                    if (!bus.enable) begin
                        state_ff <= DIR_IDLE;
                        bus.drive <= 1'b0;
                    end else if (bus.tx_idle) begin
                        if (bus.delay == 4'h0) begin
                            state_ff <= DIR_IDLE;
                            bus.drive <= 1'b0;
                        end else begin
                            state_ff <= DIR_WAIT;
                            cnt_ff <= bus.delay;
                        end
                    end
                end
                DIR_WAIT: begin
                    // A new byte during the turnaround keeps the line driven.
                    if (!bus.enable) begin
                        state_ff <= DIR_IDLE;
                        bus.drive <= 1'b0;
                    end else if (!bus.tx_idle) begin
                        state_ff <= DIR_SEND;
                    end else if (bus.bit_tick) begin
                        if (cnt_ff == 4'h1) begin
                            state_ff <= DIR_IDLE;
                            bus.drive <= 1'b0;
                        end else begin
                            cnt_ff <= cnt_ff - 4'h1;
                        end
                    end
                end
                default: begin
                    state_ff <= DIR_IDLE;
                    bus.drive <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence load_seen;
        bus.enable && !bus.tx_idle && state_ff == DIR_IDLE;
    endsequence
    sequence done_no_delay;
        bus.enable && bus.tx_idle && state_ff == DIR_SEND && bus.delay == 4'h0;
    endsequence

    dir_raise_a: assert property (load_seen |=> bus.drive)
        else $error("direction not driven after a byte was loaded");
    dir_drop_a: assert property (done_no_delay |=> !bus.drive)
        else $error("direction held with zero turnaround delay");
    dir_hold_a: assert property ((state_ff == DIR_WAIT && bus.enable && !bus.bit_tick)
        |=> bus.drive)
        else $error("direction dropped before the turnaround delay ran out");
endmodule
`default_nettype wire

// >>> hw/uartm_core.sv
// Modem status, flow control, halt and RS-485 control of one UART channel, as an APB slave.
// Assumes the transmit and receive datapaths and trigger tables sit outside, on clk_sys.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - DSR input change since last status read sets its delta flag, interrupt if enabled.
// - CTS input change since last status read sets its delta flag, interrupt if enabled.
// - RS-485 mode holds RTS for 0 to 15 bit times after last stop bit.
// - Turnaround delay field is writable only while enhanced-function enable is set.
// - Transmitter disable bit halts the transmit shifter; queued bytes wait until cleared.
// - Receiver disable bit halts the receive shifter; queued characters stay readable.
// - Eight-bit read/write scratch register, all ones after reset, kept in sleep.
// - Feature bits 7:6 pick trigger table; tables A-C use next trigger levels.
// - RS-485 mode drives RTS high on load, low after the last stop bit.
// - Transmit interrupt on shifter empty in RS-485 mode, else on holding empty.
// - Feature bit 4 selects infrared receive polarity, one meaning inverted.
// - Feature bits 3:0 set hysteresis only for table D; zero means next level.
// - Hysteresis codes map to 0,4,6,8,8,16,24,32,40,44,48,52,12,20,28,36 characters.
// - Enhanced bits 3:0 select single or dual-character software flow control.
// - Auto CTS/DSR stops transmission while selected input is high.
// - Auto RTS/DTR interrupts at trigger, raises output at upper, lowers below lower.
// - Modem control bit 2 picks RTS/CTS pair at zero, DTR/DSR at one.
// - Automatic input flow halt lets the character in progress finish.
// - Clearing enhanced enable freezes enhanced control bits; they reset to zero.
module uartm_core
    import uartm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic cd_n,
    input wire logic ri_n,
    input wire logic ir_rx,
    input wire logic bit_tick,
    input wire logic tx_hold_empty,
    input wire logic tx_shift_empty,
    input wire logic [uartm_pkg::RX_LVL_W-1:0] rx_fill,
    input wire logic [uartm_pkg::RX_LVL_W-1:0] rx_trig_level,
    input wire logic [uartm_pkg::RX_LVL_W-1:0] rx_trig_up,
    input wire logic [uartm_pkg::RX_LVL_W-1:0] rx_trig_dn,
    output logic rts_n,
    output logic dtr_n,
    output logic tx_start_en,
    output logic rx_shift_en,
    output logic tx_irq,
    output logic rx_trig_irq,
    output logic modem_irq,
    output logic ir_rx_data,
    output logic [1:0] trig_table,
    output logic [3:0] sw_flow_sel,
    output logic tx_dual_char,
    output logic rx_dual_char
);
    import uartm_pkg::*;

    logic [7:0] scratch_ff;
    logic [7:0] feature_ff;
    logic [7:0] enhanced_ff;
    logic [7:0] modem_ctl_ff;
    logic [7:0] int_en_ff;
    logic [7:0] turn_halt_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [3:0] lvl;
    logic [3:0] delta;
    logic ir_meta_ff;
    logic ir_sync_ff;
    logic ir_data_ff;
    logic flow_stop_ff;
    logic rts_n_ff;
    logic dtr_n_ff;
    logic tx_start_ff;
    logic rx_shift_ff;
    logic tx_irq_ff;
    logic rx_trig_ff;
    logic modem_irq_ff;
    logic commit;
    logic wr_en;
    logic rd_status;
    logic enh_on;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic sel_in_high;
    logic [RX_LVL_W-1:0] hyst;
    logic [RX_LVL_W-1:0] lvl_up;
    logic [RX_LVL_W-1:0] lvl_dn;
    logic use_hyst;
    logic tx_dual_ff;
    logic rx_dual_ff;

    uartm_rs485_if dir_if ();

    // Delta flags: bit 3 carrier, bit 2 ring trailing edge, bit 1 DSR, bit 0 CTS.
    uartm_delta #(.RISE_ONLY(1'b0)) u_cd (
        .clk_sys(clk_sys), .resetn(resetn), .pin_n(cd_n), .clr(rd_status),
        .level_ff(lvl[3]), .flag_ff(delta[3]));
    uartm_delta #(.RISE_ONLY(1'b1)) u_ri (
        .clk_sys(clk_sys), .resetn(resetn), .pin_n(ri_n), .clr(rd_status),
        .level_ff(lvl[2]), .flag_ff(delta[2]));
    uartm_delta #(.RISE_ONLY(1'b0)) u_dsr (
        .clk_sys(clk_sys), .resetn(resetn), .pin_n(dsr_n), .clr(rd_status),
        .level_ff(lvl[1]), .flag_ff(delta[1]));
    uartm_delta #(.RISE_ONLY(1'b0)) u_cts (
        .clk_sys(clk_sys), .resetn(resetn), .pin_n(cts_n), .clr(rd_status),
        .level_ff(lvl[0]), .flag_ff(delta[0]));

    uartm_turnaround u_dir (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .bus(dir_if.dir)
    );

    assign dir_if.enable = feature_ff[FC_RS485_BIT];
    assign dir_if.bit_tick = bit_tick;
    assign dir_if.tx_idle = tx_hold_empty & tx_shift_empty;
    assign dir_if.delay = turn_halt_ff[7:4];

    // APB: one wait state, then the access completes.
    assign commit = psel & penable & pready_ff;
    assign wr_en = commit & pwrite;
    assign rd_status = commit & ~pwrite & (paddr == OFS_MODEM_STATUS);
    assign enh_on = enhanced_ff[ENH_ENABLE_BIT];

    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (paddr)
            OFS_MODEM_STATUS: rd_byte = {~lvl, delta};
            OFS_SCRATCH_PAD: rd_byte = scratch_ff;
            OFS_FEATURE_CONTROL: rd_byte = feature_ff;
            OFS_ENHANCED_FEATURE: rd_byte = enhanced_ff;
            OFS_MODEM_CONTROL: rd_byte = modem_ctl_ff;
            OFS_INTERRUPT_ENABLE: rd_byte = int_en_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            if (psel && penable && !pready_ff) begin
                pslverr_ff <= ~rd_hit;
                prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end
        end
    end

    // Scratch pad has no sleep dependency, so its contents survive sleep.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            scratch_ff <= SCRATCH_RST;
        end else if (wr_en && paddr == OFS_SCRATCH_PAD) begin
            scratch_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            feature_ff <= FEATURE_RST;
            enhanced_ff <= ENHANCED_RST;
        end else begin
            if (wr_en && paddr == OFS_FEATURE_CONTROL) begin
                feature_ff <= pwdata[7:0];
            end
            if (wr_en && paddr == OFS_ENHANCED_FEATURE) begin
                enhanced_ff <= pwdata[7:0];
            end
        end
    end

    // Enhanced bits freeze while the enable is clear; legacy modem-control and interrupt-enable bits always write, the turnaround/halt register not at all.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            turn_halt_ff <= TURN_HALT_RST;
            modem_ctl_ff <= MODEM_CTL_RST;
            int_en_ff <= INT_EN_RST;
        end else if (wr_en) begin
            if (paddr == OFS_MODEM_STATUS && enh_on) begin
                turn_halt_ff <= pwdata[7:0] & TURN_ENH_MASK;
            end
            if (paddr == OFS_MODEM_CONTROL) begin
                modem_ctl_ff <= enh_on ? pwdata[7:0] :
                    ((modem_ctl_ff & MODEM_CTL_ENH_MASK) | (pwdata[7:0] & ~MODEM_CTL_ENH_MASK));
            end
            if (paddr == OFS_INTERRUPT_ENABLE) begin
                int_en_ff <= enh_on ? pwdata[7:0] :
                    ((int_en_ff & INT_EN_ENH_MASK) | (pwdata[7:0] & ~INT_EN_ENH_MASK));
            end
        end
    end

    // Infrared receive data after two synchronising stages.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ir_meta_ff <= 1'b0;
            ir_sync_ff <= 1'b0;
            ir_data_ff <= 1'b0;
        end else begin
            ir_meta_ff <= ir_rx;
            ir_sync_ff <= ir_meta_ff;
            ir_data_ff <= ir_sync_ff ^ feature_ff[FC_IRPOL_BIT];
        end
    end

    // Flow thresholds: table D with a nonzero code uses trigger plus or minus hysteresis.
    assign hyst = uartm_hyst(feature_ff[3:0]);
    assign use_hyst = (feature_ff[7:6] == TABLE_D) && (feature_ff[3:0] != 4'h0);
    assign lvl_up = use_hyst ? RX_LVL_W'(rx_trig_level + hyst) : rx_trig_up;
    assign lvl_dn = use_hyst ? ((rx_trig_level > hyst) ? RX_LVL_W'(rx_trig_level - hyst) :
        {RX_LVL_W{1'b0}}) : rx_trig_dn;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flow_stop_ff <= 1'b0;
            rx_trig_ff <= 1'b0;
        end else begin
            rx_trig_ff <= (rx_fill >= rx_trig_level);
            if (rx_fill >= lvl_up) begin
                flow_stop_ff <= 1'b1;
            end else if (rx_fill < lvl_dn) begin
                flow_stop_ff <= 1'b0;
            end
        end
    end

    // Pin levels: a low pin level means the output is asserted, except RTS in RS-485 mode, which is high while driving.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rts_n_ff <= 1'b1;
            dtr_n_ff <= 1'b1;
        end else begin
            if (feature_ff[FC_RS485_BIT]) begin
                rts_n_ff <= dir_if.drive;
            end else begin
                rts_n_ff <= ~modem_ctl_ff[MC_RTS_BIT] | (enhanced_ff[ENH_AUTO_RTS_BIT] &
                    ~modem_ctl_ff[MC_PAIR_BIT] & flow_stop_ff);
            end
            dtr_n_ff <= ~modem_ctl_ff[MC_DTR_BIT] | (enhanced_ff[ENH_AUTO_RTS_BIT] &
                modem_ctl_ff[MC_PAIR_BIT] & flow_stop_ff);
        end
    end

    // Only new character starts are gated, so a character in progress always completes.
    assign sel_in_high = modem_ctl_ff[MC_PAIR_BIT] ? lvl[1] : lvl[0];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_start_ff <= 1'b0;
            rx_shift_ff <= 1'b0;
        end else begin
            tx_start_ff <= ~turn_halt_ff[TH_TX_OFF_BIT] &
                ~(enhanced_ff[ENH_AUTO_CTS_BIT] & sel_in_high) &
                (~feature_ff[FC_RS485_BIT] | dir_if.drive);
            rx_shift_ff <= ~turn_halt_ff[TH_RX_OFF_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_irq_ff <= 1'b0;
            modem_irq_ff <= 1'b0;
        end else begin
            tx_irq_ff <= feature_ff[FC_RS485_BIT] ? (tx_hold_empty & tx_shift_empty) :
                tx_hold_empty;
            modem_irq_ff <= int_en_ff[IEN_MODEM_BIT] & (|delta);
        end
    end

    // Dual-character modes need both select bits of one direction; registered so pins come from flops.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_dual_ff <= 1'b0;
            rx_dual_ff <= 1'b0;
        end else begin
            tx_dual_ff <= enhanced_ff[3] & enhanced_ff[2];
            rx_dual_ff <= enhanced_ff[1] & enhanced_ff[0];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign rts_n = rts_n_ff;
    assign dtr_n = dtr_n_ff;
    assign tx_start_en = tx_start_ff;
    assign rx_shift_en = rx_shift_ff;
    assign tx_irq = tx_irq_ff;
    assign rx_trig_irq = rx_trig_ff;
    assign modem_irq = modem_irq_ff;
    assign ir_rx_data = ir_data_ff;
    assign trig_table = feature_ff[7:6];
    assign sw_flow_sel = enhanced_ff[3:0];
    assign tx_dual_char = tx_dual_ff;
    assign rx_dual_char = rx_dual_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    dsr_delta_a: assert property ($changed(lvl[1]) |=> delta[1])
        else $error("DSR change did not set its delta flag");
    cts_delta_a: assert property ($changed(lvl[0]) |=> delta[0])
        else $error("CTS change did not set its delta flag");
    status_clear_a: assert property ((rd_status && $stable(lvl)) ##1 $stable(lvl)
        |-> delta == 4'h0)
        else $error("status read did not clear delta flags");
    modem_irq_a: assert property ((int_en_ff[IEN_MODEM_BIT] && delta[1]) |=> modem_irq)
        else $error("modem interrupt missing with delta and enable set");
    delay_lock_a: assert property ((wr_en && paddr == OFS_MODEM_STATUS && !enh_on)
        |=> $stable(turn_halt_ff))
        else $error("turnaround field changed with enhanced functions disabled");
    tx_halt_a: assert property (turn_halt_ff[TH_TX_OFF_BIT] [*2] |-> !tx_start_en)
        else $error("transmit start allowed while transmitter disabled");
    rx_halt_a: assert property (turn_halt_ff[TH_RX_OFF_BIT] |=> !rx_shift_en)
        else $error("receive shifter enabled while receiver disabled");
    cts_stop_a: assert property ((enhanced_ff[ENH_AUTO_CTS_BIT] && sel_in_high)
        |=> !tx_start_en)
        else $error("transmit start allowed while flow input is high");
    flow_raise_a: assert property ((enhanced_ff[ENH_AUTO_RTS_BIT] && !feature_ff[FC_RS485_BIT]
        && !modem_ctl_ff[MC_PAIR_BIT] && rx_fill >= lvl_up) |-> ##2 rts_n)
        else $error("RTS not raised at the upper flow level");
    tx_irq_a: assert property ((feature_ff[FC_RS485_BIT] && !tx_shift_empty) |=> !tx_irq)
        else $error("transmit interrupt before shifter empty in RS-485 mode");
    scratch_rst_a: assert property ($rose(resetn) |-> scratch_ff == SCRATCH_RST)
        else $error("scratch pad not all ones after reset");
    mc_lock_a: assert property ((wr_en && paddr == OFS_MODEM_CONTROL && !enh_on)
        |=> ((modem_ctl_ff ^ $past(modem_ctl_ff)) & MODEM_CTL_ENH_MASK) == 8'h00)
        else $error("enhanced modem control bits changed while locked");
endmodule
`default_nettype wire

// >>> test/uartm_modem.sv
// Modem model for the serial side: drives the modem status and infrared pins.
// Assumes the bench sets the wanted levels; the pins follow one edge later.
`timescale 1ns/1ns
`default_nettype none
module uartm_modem (
    input wire logic clk_sys,
    input wire logic [4:0] want,
    output logic cts_n,
    output logic dsr_n,
    output logic cd_n,
    output logic ri_n,
    output logic ir_rx
);
    // The pins change only just after an edge, as a real modem could not be timed to the clock.
    always_ff @(posedge clk_sys) begin
        {ir_rx, ri_n, cd_n, dsr_n, cts_n} <= want;
    end
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the modem, flow and RS-485 control block.
// Assumes the core answers APB with pready and drives the modem pins through the model.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import uartm_pkg::*;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
    logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, bit_tick = 0;
    logic tx_hold_empty = 1, tx_shift_empty = 1, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0] want = 5'h0F;
    logic [6:0] rx_fill = 7'h00, rx_trig_level = 7'h20, rx_trig_up = 7'h30, rx_trig_dn = 7'h10;
    logic cts_n, dsr_n, cd_n, ri_n, ir_rx, rts_n, dtr_n, tx_start_en, rx_shift_en, tx_irq;
    logic rx_trig_irq, modem_irq, ir_rx_data, tx_dual_char, rx_dual_char;
    logic [1:0] trig_table;
    logic [3:0] sw_flow_sel;
    logic [6:0] fills [4] = '{7'h23, 7'h24, 7'h1C, 7'h1B};
    logic exp_rts [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    int num_checks = 0, miscompares = 0;
    uartm_core uartm_core_inst (.*);
    uartm_modem uartm_modem_inst (.*);
    always #25 clk_sys = ~clk_sys;
    task automatic finish_test();
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        apb(a, 1'b0, 8'h00);
        `CHK(rd[7:0], e)
    endtask
    initial begin
        tick(8);
        resetn <= 1;
        rdc(OFS_SCRATCH_PAD, 8'hFF);
        apb(OFS_SCRATCH_PAD, 1'b1, 8'h5A);
        rdc(OFS_SCRATCH_PAD, 8'h5A);
        rdc(8'h18, 8'h00);
        `CHK(err, 1'b1)
        apb(OFS_MODEM_STATUS, 1'b1, 8'h0C);
        tick(3);
        `CHK({tx_start_en, rx_shift_en}, 2'b11)
        apb(OFS_ENHANCED_FEATURE, 1'b1, 8'h10);
        apb(OFS_MODEM_STATUS, 1'b1, 8'h0C);
        tick(3);
        `CHK({tx_start_en, rx_shift_en}, 2'b00)
        apb(OFS_MODEM_STATUS, 1'b1, 8'h00);
        tick(3);
        `CHK({tx_start_en, rx_shift_en}, 2'b11)
        apb(OFS_INTERRUPT_ENABLE, 1'b1, 8'h08);
        want <= 5'h0D;
        tick(6);
        `CHK(modem_irq, 1'b1)
        rdc(OFS_MODEM_STATUS, 8'h22);
        rdc(OFS_MODEM_STATUS, 8'h20);
        `CHK(modem_irq, 1'b0)
        want <= 5'h0C;
        tick(6);
        rdc(OFS_MODEM_STATUS, 8'h31);
        `CHK(ir_rx_data, 1'b0)
        apb(OFS_FEATURE_CONTROL, 1'b1, 8'h10);
        tick(3);
        `CHK(ir_rx_data, 1'b1)
        want <= 5'h1C;
        tick(6);
        `CHK(ir_rx_data, 1'b0)
        apb(OFS_ENHANCED_FEATURE, 1'b1, 8'h93);
        rdc(OFS_ENHANCED_FEATURE, 8'h93);
        `CHK({sw_flow_sel, tx_dual_char, rx_dual_char}, 6'h0D)
        want <= 5'h0D;
        tick(6);
        `CHK(tx_start_en, 1'b0)
        apb(OFS_MODEM_CONTROL, 1'b1, 8'h04);
        tick(3);
        `CHK(tx_start_en, 1'b1)
        apb(OFS_ENHANCED_FEATURE, 1'b1, 8'h10);
        apb(OFS_ENHANCED_FEATURE, 1'b1, 8'h50);
        apb(OFS_MODEM_CONTROL, 1'b1, 8'h02);
        apb(OFS_FEATURE_CONTROL, 1'b1, 8'hC1);
        tick(3);
        `CHK({trig_table, rts_n}, 3'b110)
        foreach (fills[i]) begin
            rx_fill <= fills[i];
            tick(4);
            `CHK({rts_n, rx_trig_irq}, {exp_rts[i], fills[i] >= rx_trig_level})
        end
        apb(OFS_FEATURE_CONTROL, 1'b1, 8'h20);
        apb(OFS_MODEM_STATUS, 1'b1, 8'h20);
        tx_shift_empty <= 0;
        tick(4);
        `CHK({rts_n, tx_irq}, 2'b10)
        tx_shift_empty <= 1;
        tick(3);
        for (int i = 0; i < 2; i++) begin
            `CHK(rts_n, 1'b1)
            bit_tick <= 1;
            tick(1);
            bit_tick <= 0;
            tick(3);
        end
        tick(3);
        `CHK(rts_n, 1'b0)
        apb(OFS_MODEM_STATUS, 1'b1, 8'h00);
        tx_shift_empty <= 0;
        tick(4);
        `CHK(rts_n, 1'b1)
        tx_shift_empty <= 1;
        tick(3);
        `CHK(rts_n, 1'b0)
        apb(OFS_FEATURE_CONTROL, 1'b1, 8'h00);
        tx_shift_empty <= 0;
        tick(4);
        `CHK(tx_irq, 1'b1)
        tx_hold_empty <= 0;
        tick(3);
        `CHK(tx_irq, 1'b0)
        apb(OFS_ENHANCED_FEATURE, 1'b1, 8'h00);
        apb(OFS_MODEM_CONTROL, 1'b1, 8'hFF);
        rdc(OFS_MODEM_CONTROL, 8'h13);
        `CHK({rts_n, dtr_n}, 2'b00)
        finish_test();
    end
endmodule
`default_nettype wire
